// ### design/eeprom_rd_master.sv
// bus master end: issues current and random reads of 1 to 255 bytes with the default LEN_W
`timescale 1ns/1ns
module eeprom_rd_master import eeprom_rd_pkg::*; #(
    parameter int LEN_W = 8 // width of the byte count
) (
    input wire logic clk, // system clock
    input wire logic reset, // synchronous, active high
    eeprom_link_if.master link, // two-wire link
    input wire logic cmdValid, // start a read, taken when idle
    input wire logic cmdRandom, // 1 random read, 0 current read
    input wire logic [15:0] cmdAddr, // word address for random read
    input wire logic [LEN_W-1:0] cmdLen, // bytes to read, 0 acts as 1
    output logic busy, // transaction in progress
    output logic [7:0] rxData, // received byte
    output logic rxValid, // one-cycle pulse with rxData
    output logic done, // one-cycle pulse after stop
    output logic ackErr // target did not ack an address byte
);
    import eeprom_rd_pkg::*;

    mst_state_t state, next_state; // sequencer state
    logic [1:0] qCnt, next_qCnt; // cycles within a quarter
    logic [1:0] q, next_q; // quarter of the serial clock period
    logic [3:0] bitIdx, next_bitIdx; // bit within the byte, 8 is ack
    logic [1:0] byteSel, next_byteSel; // which address byte goes out
    logic [LEN_W-1:0] remain, next_remain; // bytes still to read
    logic [15:0] addr, next_addr; // latched word address
    logic [7:0] shReg, next_shReg; // shift register
    logic sclOut, next_sclOut; // serial clock level
    logic sdaOe, next_sdaOe; // pull data line low
    logic [7:0] next_rxData;
    logic next_rxValid, next_done, next_ackErr, next_busy;
    logic sdaMeta, sdaSync; // data line synchroniser
    logic tick; // end of a quarter

    // byte to send for each plan position
    function automatic logic [7:0] txByte(input logic [1:0] sel, input logic [15:0] a);
        logic [7:0] b;
        b = {DEV_ADDR, RW_READ};
        if (sel == SEL_DEVW) begin
            b = {DEV_ADDR, RW_WRITE};
        end else if (sel == 2'h1) begin
            b = a[15:8];
        end else if (sel == SEL_ADRLO) begin
            b = a[7:0];
        end
        return b;
    endfunction

    assign tick = (qCnt == 2'(QUARTER_CYC - 1));

    // data line passes two flops before use
    always_ff @(posedge clk) begin
        if (reset) begin
            sdaMeta <= 1'h1;
            sdaSync <= 1'h1;
        end else begin
            sdaMeta <= link.sda;
            sdaSync <= sdaMeta;
        end
    end

    // next-state logic: clock divider plus quarter-phase bit engine
    always_comb begin
        next_state = state;
        next_qCnt = tick ? 2'h0 : qCnt + 2'h1;
        next_q = tick ? q + 2'h1 : q;
        next_bitIdx = bitIdx;
        next_byteSel = byteSel;
        next_remain = remain;
        next_addr = addr;
        next_shReg = shReg;
        next_sclOut = sclOut;
        next_sdaOe = sdaOe;
        next_rxData = rxData;
        next_rxValid = 1'h0;
        next_done = 1'h0;
        next_ackErr = ackErr;
        next_busy = busy;
        case (state)
            M_IDLE: begin
                // bus free: clock high, line released
                next_qCnt = 2'h0;
                next_q = 2'h0;
                next_sclOut = 1'h1;
                next_sdaOe = 1'h0;
                if (cmdValid) begin
                    next_addr = cmdAddr;
                    next_remain = (cmdLen == '0) ? LEN_W'(1) : cmdLen;
                    // random read begins with dummy write
                    next_byteSel = cmdRandom ? SEL_DEVW : SEL_DEVR;
                    next_ackErr = 1'h0;
                    next_busy = 1'h1;
                    next_state = M_START;
                end
            end
            M_START: begin
                // data changes one quarter after clock falls, never with it
                if (tick) begin
                    if (q == 2'h0) begin
                        next_sclOut = 1'h0;
                    end else if (q == 2'h1) begin
                        next_sdaOe = 1'h0;
                    end else if (q == 2'h2) begin
                        next_sclOut = 1'h1;
                    end else begin
                        // falling data under high clock
                        next_sdaOe = 1'h1;
                        next_bitIdx = 4'h0;
                        next_shReg = txByte(byteSel, addr);
                        next_state = M_TXB;
                    end
                end
            end
            M_TXB, M_RXB: begin
                if (tick) begin
                    if (q == 2'h0) begin
                        next_sclOut = 1'h0;
                    end else if (q == 2'h1) begin
                        if (bitIdx == LAST_BIT) begin
                            // ack if more wanted; nack on last
                            next_sdaOe = (state == M_RXB) && (remain != LEN_W'(1));
                        end else begin
                            next_sdaOe = (state == M_TXB) && !shReg[7];
                        end
                    end else if (q == 2'h2) begin
                        next_sclOut = 1'h1;
                    end else if (bitIdx != LAST_BIT) begin
                        next_shReg = {shReg[6:0], sdaSync};
                        next_bitIdx = bitIdx + 4'h1;
                    end else begin
                        next_bitIdx = 4'h0;
                        if (state == M_RXB) begin
                            next_rxData = shReg;
                            next_rxValid = 1'h1;
                            next_remain = remain - LEN_W'(1);
                            if (remain == LEN_W'(1)) begin
                                next_state = M_STOP;
                            end
                        end else if (sdaSync) begin
                            // no ack from target: give up
                            next_ackErr = 1'h1;
                            next_state = M_STOP;
                        end else if (byteSel == SEL_ADRLO) begin
                            // repeated start, no data, no stop
                            next_byteSel = SEL_DEVR;
                            next_state = M_START;
                        end else if (byteSel == SEL_DEVR) begin
                            next_state = M_RXB;
                        end else begin
                            next_byteSel = byteSel + 2'h1;
                            next_shReg = txByte(byteSel + 2'h1, addr);
                        end
                    end
                end
            end
            default: begin
                // stop: rising data under high clock
                if (tick) begin
                    if (q == 2'h0) begin
                        next_sclOut = 1'h0;
                    end else if (q == 2'h1) begin
                        next_sdaOe = 1'h1;
                    end else if (q == 2'h2) begin
                        next_sclOut = 1'h1;
                    end else begin
                        next_sdaOe = 1'h0;
                        next_busy = 1'h0;
                        next_done = 1'h1;
                        next_state = M_IDLE;
                    end
                end
            end
        endcase
    end

    // register stage
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= M_IDLE;
            qCnt <= 2'h0;
            q <= 2'h0;
            bitIdx <= 4'h0;
            byteSel <= 2'h0;
            remain <= '0;
            addr <= 16'h0000;
            shReg <= 8'h00;
            sclOut <= 1'h1;
            sdaOe <= 1'h0;
            rxData <= 8'h00;
            rxValid <= 1'h0;
            done <= 1'h0;
            ackErr <= 1'h0;
            busy <= 1'h0;
        end else begin
            state <= next_state;
            qCnt <= next_qCnt;
            q <= next_q;
            bitIdx <= next_bitIdx;
            byteSel <= next_byteSel;
            remain <= next_remain;
            addr <= next_addr;
            shReg <= next_shReg;
            sclOut <= next_sclOut;
            sdaOe <= next_sdaOe;
            rxData <= next_rxData;
            rxValid <= next_rxValid;
            done <= next_done;
            ackErr <= next_ackErr;
            busy <= next_busy;
        end
    end

    // open drain data, value always low
    assign link.scl = sclOut;
    assign link.mSdaOe = sdaOe;
    assign link.mSdaOut = 1'h0;
endmodule

// ### design/eeprom_rd_pkg.sv
// shared constants and state types for the two-wire eeprom read link
package eeprom_rd_pkg;
    // clock and serial clock timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int SCL_PERIOD_NS = 800;
    // one quarter of a serial clock period, in clk cycles
    localparam int QUARTER_CYC = SCL_PERIOD_NS / (4 * CLK_PERIOD_NS);
    // device address byte layout
    localparam logic [6:0] DEV_ADDR = 7'h50;
    localparam logic RW_READ = 1'h1;
    localparam logic RW_WRITE = 1'h0;
    // word address width of the larger density
    localparam int ADDR_W = 15;
    // bits in one byte on the wire, the ninth is the acknowledge
    localparam logic [3:0] LAST_BIT = 4'h8;
    // byte plan positions of the master
    localparam logic [1:0] SEL_DEVW = 2'h0;
    localparam logic [1:0] SEL_ADRLO = 2'h2;
    localparam logic [1:0] SEL_DEVR = 2'h3;

    // target states
    typedef enum logic [2:0] {
        D_IDLE = 3'b000,
        D_RXDEV = 3'b001,
        D_RXHI = 3'b010,
        D_RXLO = 3'b011,
        D_RXDAT = 3'b100,
        D_ACK = 3'b101,
        D_TX = 3'b110,
        D_TXACK = 3'b111
    } dev_state_t;

    // master states
    typedef enum logic [2:0] {
        M_IDLE = 3'b000,
        M_START = 3'b001,
        M_TXB = 3'b010,
        M_RXB = 3'b011,
        M_STOP = 3'b100
    } mst_state_t;
endpackage

// ### design/eeprom_link_if.sv
// two-wire link between bus master and eeprom target
`timescale 1ns/1ns
interface eeprom_link_if;
    logic scl; // serial clock, driven by master only
    logic mSdaOut; // master data out value
    logic mSdaOe; // master drives data line
    logic dSdaOut; // target data out value
    logic dSdaOe; // target drives data line
    logic sda; // resolved data line level

    // open drain with pull-up: any enabled low driver wins
    assign sda = !((mSdaOe && !mSdaOut) || (dSdaOe && !dSdaOut));

    modport master (output scl, output mSdaOut, output mSdaOe, input sda);
    modport target (input scl, input sda, output dSdaOut, output dSdaOe);
endinterface

// ### design/eeprom_rd_target.sv
// eeprom target end: read engine with word address counter
//
// What this block does
// - read/write select bit one means read
// - counter holds last accessed address plus one
// - counter survives transactions, no bus clearing
// - read counter wraps from top to zero
// - current read sends byte at counter
// - master ends current read: nack, stop
// - random read acks, loads word address
// - master dummy-writes address then repeated start
// - after restart, read address acked, data sent
// - master ends random read: nack, stop
// - master acks each byte wanting more
// - each master ack advances and sends next
// - sequential read wraps without interruption
// - nack then stop ends read, target releases
// - target acks every received byte except a non-matching device address, ninth clock
// - word address is two bytes, high first
// - stop returns target to standby
`timescale 1ns/1ns
module eeprom_rd_target import eeprom_rd_pkg::*; #(
    parameter int AW = eeprom_rd_pkg::ADDR_W // 15 for larger, 14 for smaller density
) (
    input wire logic clk, // system clock
    input wire logic reset, // synchronous, active high
    eeprom_link_if.target link, // two-wire link
    input wire logic memWe, // backdoor array load strobe
    input wire logic [AW-1:0] memAddr, // backdoor load address
    input wire logic [7:0] memData, // backdoor load data
    output logic [AW-1:0] wordAddr, // word address counter
    output logic standby // high while in standby
);
    import eeprom_rd_pkg::*;

    localparam int DEPTH = 1 << AW;

    logic [7:0] mem [DEPTH]; // storage array, no reset
    logic [7:0] memRd; // byte at the counter
    logic sclMeta, sclSync, sclPrev; // serial clock synchroniser and history
    logic sdaMeta, sdaSync, sdaPrev; // data line synchroniser and history
    logic sclRise, sclFall, startSeen, stopSeen; // bus events
    dev_state_t state, next_state; // protocol state
    dev_state_t retState, next_retState; // where to go after our ack
    logic [3:0] bitCnt, next_bitCnt; // bits seen in the current byte
    logic [7:0] shReg, next_shReg; // shift register, both directions
    logic [7:0] hiByte, next_hiByte; // high word address byte
    logic [AW-1:0] ptr, next_ptr; // word address counter
    logic ackSeen, next_ackSeen; // master acked the last sent byte
    logic sdaOe, next_sdaOe; // pull data line low
    logic sdaOut; // driven level, always low
    logic load; // fetch next byte and start sending

    // backdoor write stands in for the write path
    always_ff @(posedge clk) begin
        if (memWe) begin
            mem[memAddr] <= memData;
        end
    end

    assign memRd = mem[ptr];

    // two flops per pin, a third keeps history for edges
    always_ff @(posedge clk) begin
        if (reset) begin
            sclMeta <= 1'h1;
            sclSync <= 1'h1;
            sclPrev <= 1'h1;
            sdaMeta <= 1'h1;
            sdaSync <= 1'h1;
            sdaPrev <= 1'h1;
        end else begin
            sclMeta <= link.scl;
            sclSync <= sclMeta;
            sclPrev <= sclSync;
            sdaMeta <= link.sda;
            sdaSync <= sdaMeta;
            sdaPrev <= sdaSync;
        end
    end

    // edge and condition detect on the synchronised lines
    assign sclRise = sclSync && !sclPrev;
    assign sclFall = !sclSync && sclPrev;
    assign startSeen = sclSync && sclPrev && sdaPrev && !sdaSync;
    assign stopSeen = sclSync && sclPrev && !sdaPrev && sdaSync;

    // next-state logic of the byte engine
    always_comb begin
        next_state = state;
        next_retState = retState;
        next_bitCnt = bitCnt;
        next_shReg = shReg;
        next_hiByte = hiByte;
        next_ptr = ptr;
        next_ackSeen = ackSeen;
        next_sdaOe = sdaOe;
        load = 1'h0;
        if (stopSeen) begin
            next_state = D_IDLE;
            next_sdaOe = 1'h0;
        end else if (startSeen) begin
            next_state = D_RXDEV;
            next_bitCnt = 4'h0;
            next_sdaOe = 1'h0;
        end else begin
            case (state)
                D_RXDEV, D_RXHI, D_RXLO, D_RXDAT: begin
                    // sample on rising serial clock
                    if (sclRise) begin
                        next_shReg = {shReg[6:0], sdaSync};
                        next_bitCnt = bitCnt + 4'h1;
                    end
                    if (sclFall && bitCnt == LAST_BIT) begin
                        next_bitCnt = 4'h0;
                        next_sdaOe = 1'h1;
                        next_state = D_ACK;
                        case (state)
                            D_RXDEV: begin
                                if (shReg[0] == RW_READ) begin
                                    next_retState = D_TX;
                                end else begin
                                    next_retState = D_RXHI;
                                end
                                // no match: stay silent
                                if (shReg[7:1] != DEV_ADDR) begin
                                    next_sdaOe = 1'h0;
                                    next_state = D_IDLE;
                                end
                            end
                            D_RXHI: begin
                                next_hiByte = shReg;
                                next_retState = D_RXLO;
                            end
                            D_RXLO: begin
                                // load word address, top bits dropped
                                next_ptr = AW'({hiByte, shReg});
                                next_retState = D_RXDAT;
                            end
                            default: begin
                                // write data belongs to the write path, acked only
                                next_retState = D_RXDAT;
                            end
                        endcase
                    end
                end
                D_ACK: begin
                    // release after the ninth clock
                    if (sclFall) begin
                        next_sdaOe = 1'h0;
                        if (retState == D_TX) begin
                            load = 1'h1;
                        end else begin
                            next_state = retState;
                        end
                    end
                end
                D_TX: begin
                    // bits leave on falling, master samples on rising
                    if (sclRise) begin
                        next_bitCnt = bitCnt + 4'h1;
                    end
                    if (sclFall) begin
                        if (bitCnt == LAST_BIT) begin
                            next_sdaOe = 1'h0;
                            next_state = D_TXACK;
                        end else begin
                            next_shReg = {shReg[6:0], 1'h0};
                            next_sdaOe = !shReg[6];
                        end
                    end
                end
                D_TXACK: begin
                    // low on the ninth clock means another byte wanted
                    if (sclRise) begin
                        next_ackSeen = !sdaSync;
                    end
                    if (sclFall) begin
                        if (ackSeen) begin
                            load = 1'h1;
                        end else begin
                            next_state = D_IDLE;
                        end
                    end
                end
                default: begin
                    // standby: only a start wakes us
                    next_sdaOe = 1'h0;
                end
            endcase
        end
        if (load) begin
            // counter is last accessed plus one
            next_ptr = ptr + AW'(1);
            next_shReg = memRd;
            next_sdaOe = !memRd[7];
            next_bitCnt = 4'h0;
            next_ackSeen = 1'h0;
            next_state = D_TX;
        end
    end

    // register stage; the counter is cleared only at power-on reset
    always_ff @(posedge clk) begin
        if (reset) begin
            state <= D_IDLE;
            retState <= D_IDLE;
            bitCnt <= 4'h0;
            shReg <= 8'h00;
            hiByte <= 8'h00;
            ptr <= '0;
            ackSeen <= 1'h0;
            sdaOe <= 1'h0;
            sdaOut <= 1'h0;
            wordAddr <= '0;
            standby <= 1'h1;
        end else begin
            state <= next_state;
            retState <= next_retState;
            bitCnt <= next_bitCnt;
            shReg <= next_shReg;
            hiByte <= next_hiByte;
            ptr <= next_ptr;
            ackSeen <= next_ackSeen;
            sdaOe <= next_sdaOe;
            sdaOut <= 1'h0;
            wordAddr <= next_ptr;
            standby <= (next_state == D_IDLE);
        end
    end

    // open drain: value is always low, enable does the work
    assign link.dSdaOe = sdaOe;
    assign link.dSdaOut = sdaOut;
endmodule

// ### tb/eeprom_link_chk.sv
// concurrent checks on the two-wire link between bus master and eeprom target
`timescale 1ns/1ns
module eeprom_link_chk (
    input wire logic clk, // system clock
    input wire logic reset, // synchronous, active high
    input wire logic scl, // serial clock
    input wire logic mSdaOut, // master data value
    input wire logic mSdaOe, // master pulls data low
    input wire logic dSdaOut, // target data value
    input wire logic dSdaOe, // target pulls data low
    input wire logic sda // resolved data line
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // open drain: an enabled driver on either end only ever pulls low
    property p_tgt_low; (dSdaOe || mSdaOe) |-> dSdaOut == 1'b0 && mSdaOut == 1'b0; endproperty
    a_tgt_low: assert property (p_tgt_low) else $error("target drives data high");
    // longest target hold is its ack plus one all-zero byte, then it must let go
    property p_tgt_release; $rose(dSdaOe) |-> ##[1:80] !dSdaOe; endproperty
    a_tgt_release: assert property (p_tgt_release) else $error("target holds data line too long");
    // high phase of the serial clock lasts two quarters
    property p_scl_high; $rose(scl) |-> scl [*4]; endproperty
    a_scl_high: assert property (p_scl_high) else $error("serial clock high too short");
    // low phase is exactly two quarters, so each bit takes eight cycles
    property p_scl_low; $fell(scl) |-> !scl [*4] ##1 scl; endproperty
    a_scl_low: assert property (p_scl_low) else $error("serial clock low phase wrong");
    // target data and ack may only change while the clock is low
    property p_tgt_hold; scl && $past(scl) |-> $stable(dSdaOe); endproperty
    a_tgt_hold: assert property (p_tgt_hold) else $error("target data moved with clock high");
    // a low bit from the target must cover a whole clock high phase
    property p_tgt_pulse; $rose(dSdaOe) |-> dSdaOe [*5]; endproperty
    a_tgt_pulse: assert property (p_tgt_pulse) else $error("target low bit too short");
    // starts, repeated ones too, come from the master with the target quiet
    property p_start_mst; scl && $past(scl) && $fell(sda) |-> mSdaOe && !dSdaOe; endproperty
    a_start_mst: assert property (p_start_mst) else $error("start not made by master");
    // a stop is the master releasing the line while the target is released
    property p_stop_mst; scl && $past(scl) && $rose(sda) |-> !dSdaOe && $past(mSdaOe); endproperty
    a_stop_mst: assert property (p_stop_mst) else $error("stop not made by master");
    c_tgt_drive: cover property ($rose(dSdaOe));
    c_start: cover property (scl && $past(scl) && $fell(sda));
    c_stop: cover property (scl && $past(scl) && $rose(sda));
endmodule

// ### tb/serial_eeprom_read_engine_tb.sv
// self-checking bench: master and target joined over the two-wire link
`timescale 1ns/1ns
module serial_eeprom_read_engine_tb;
    import eeprom_rd_pkg::*;
    localparam int AW = 14; // smaller density, top address bit ignored
    logic clk = 1'b0, reset = 1'b1; // clock and reset
    logic memWe = 1'b0, cmdValid = 1'b0, cmdRandom = 1'b0; // strobes
    logic [AW-1:0] memAddr = '0, wordAddr; // backdoor address, counter
    logic [7:0] memData = 8'h00, rxData, lfsr = 8'h11; // data, random state
    logic [15:0] cmdAddr = 16'h0000; // random read address
    logic [7:0] cmdLen = 8'h00; // byte count
    logic standby, busy, rxValid, done, ackErr; // status
    logic [7:0] mem [logic [AW-1:0]]; // bench copy of the array
    logic [7:0] expq [$]; // expected bytes, oldest first
    logic [AW-1:0] ptr = '0; // expected counter value
    int n_mismatch = 0, n_checks = 0; // counters
    eeprom_link_if link ();
    eeprom_rd_target #(.AW(AW)) u_eeprom_rd_target (.clk(clk), .reset(reset), .link(link), .memWe(memWe),
        .memAddr(memAddr), .memData(memData), .wordAddr(wordAddr), .standby(standby));
    eeprom_rd_master u_eeprom_rd_master (.clk(clk), .reset(reset), .link(link), .cmdValid(cmdValid),
        .cmdRandom(cmdRandom), .cmdAddr(cmdAddr), .cmdLen(cmdLen), .busy(busy), .rxData(rxData),
        .rxValid(rxValid), .done(done), .ackErr(ackErr));
    eeprom_link_chk u_eeprom_link_chk (.clk(clk), .reset(reset), .scl(link.scl), .mSdaOut(link.mSdaOut),
        .mSdaOe(link.mSdaOe), .dSdaOut(link.dSdaOut), .dSdaOe(link.dSdaOe), .sda(link.sda));
    // 10 MHz system clock
    always #50 clk = ~clk;
    // random byte source, fixed start value
    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction
    // one compare for every kind of result, an unknown matches only the identical unknown
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask
    // closing verdict, the single end of the run
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // result watcher: each received byte takes the oldest note
    always @(negedge clk) begin
        if (rxValid === 1'b1) begin
            if (expq.size() == 0) chk("unplanned byte", 16'h0000, 16'h0001);
            else chk("read byte", {8'h00, expq.pop_front()}, {8'h00, rxData});
        end
    end
    // issue one read, note the bytes it must return, wait for the stop
    task automatic rd(input logic rnd, input logic [15:0] a, input int len);
        int k;
        if (rnd) ptr = a[AW-1:0];
        // a zero count still reads one byte
        for (k = 0; k < ((len == 0) ? 1 : len); k++) begin
            expq.push_back(mem[ptr]);
            ptr = ptr + 1'b1;
        end
        @(posedge clk);
        cmdValid <= 1'b1;
        cmdRandom <= rnd;
        cmdAddr <= a;
        cmdLen <= 8'(len);
        @(posedge clk);
        cmdValid <= 1'b0;
        @(negedge clk);
        chk("busy on", 16'h0001, {15'h0000, busy});
        k = 0;
        while (done !== 1'b1 && k < 5000) begin
            @(negedge clk);
            k++;
        end
        chk("done seen", 16'h0001, {15'h0000, done});
        chk("busy off", 16'h0000, {15'h0000, busy});
        chk("queue drained", 16'h0000, 16'(expq.size()));
        chk("word address", {2'b00, ptr}, {2'b00, wordAddr});
        chk("address ack", 16'h0000, {15'h0000, ackErr});
        repeat (2) @(negedge clk);
        chk("standby", 16'h0001, {15'h0000, standby});
    endtask
    // hang guard, far beyond the expected run length
    initial begin
        #2000000;
        n_mismatch++;
        summarize();
    end
    // main sequence
    initial begin
        int i;
        repeat (10) @(posedge clk);
        reset <= 1'b0;
        @(negedge clk);
        chk("reset standby", 16'h0001, {15'h0000, standby});
        // load the low sixteen and the top four bytes with random data
        for (i = 0; i < 20; i++) begin
            lfsr = lfsr_next(lfsr);
            @(posedge clk);
            memWe <= 1'b1;
            memAddr <= (i < 16) ? AW'(i) : AW'(14'h3fec + i);
            memData <= lfsr;
            mem[(i < 16) ? AW'(i) : AW'(14'h3fec + i)] = lfsr;
        end
        @(posedge clk);
        memWe <= 1'b0;
        // current reads start from the counter, which reset cleared
        rd(1'b0, 16'h0000, 2);
        $display("test 1 done");
        // random read near the top, wraps on, top address bit ignored
        rd(1'b1, 16'hfffd, 5);
        $display("test 2 done");
        // counter kept across transactions
        rd(1'b0, 16'h0000, 1);
        $display("test 3 done");
        // random single byte with the ignored top bit set
        rd(1'b1, 16'h4005, 1);
        $display("test 4 done");
        // long sequential current read from the loaded address plus one
        rd(1'b0, 16'h0000, 10);
        $display("test 5 done");
        // random read with a zero count, which the master treats as one byte
        rd(1'b1, 16'h0007, 0);
        $display("test 6 done");
        summarize();
    end
endmodule
